// file: common/stc_pkg.sv
package stc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_ADDR = 32'h0fffe808;
  localparam logic [31:0] TPR0_ADDR = 32'h0fffe80c;
  localparam logic [31:0] TPR1_ADDR = 32'hffffe810;
  localparam logic [31:0] TPR2_ADDR = 32'h0fffe814;
  localparam logic [31:0] WPMR_ADDR = 32'h0fffe840;

  localparam logic [31:0] CFG_WMASK = 32'h00557000;
  localparam logic [31:0] CFG_RST = 32'h00007000;
  localparam logic [31:0] TPR0_WMASK = 32'hffffffff;
  localparam logic [31:0] TPR0_RST = 32'h20227225;
  localparam logic [31:0] TPR1_WMASK = 32'h0fffff1f;
  localparam logic [31:0] TPR1_RST = 32'h03c80808;
  localparam logic [31:0] TPR2_WMASK = 32'h000f7fff;
  localparam logic [31:0] TPR2_RST = 32'h00042062;
  localparam logic [31:0] WPMR_WMASK = 32'h00000001;
  localparam logic [31:0] WPMR_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam int NBANK = 8;
  localparam int G_RC = 0;
  localparam int G_RRD = 1;
  localparam int G_RP = 2;
  localparam int G_RPA = 3;
  localparam int G_MRD = 4;
  localparam int G_RFC = 5;
  localparam int G_WTR = 6;
  localparam int G_XSNR = 7;
  localparam int G_XSRD = 8;
  localparam int G_XP = 9;
  localparam int G_XARD = 10;
  localparam int G_XARDS = 11;
  localparam int G_NUM = 12;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MEM_SDR, MEM_LPSDR, MEM_LPDDR1, MEM_DDR2}
    stc_mem_t;
  typedef enum logic [3:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PREA,
    OP_REF, OP_LMR, OP_BST} stc_op_t;
  typedef enum logic [1:0] {CKE_SELFREF, CKE_PD_PRE, CKE_PD_FAST,
    CKE_PD_SLOW} stc_cke_cause_t;

  typedef struct packed {
    logic valid;
    stc_op_t op;
    logic [2:0] bank;
  } stc_cmd_t;

  typedef struct packed {
    logic rise;
    stc_cke_cause_t cause;
  } stc_cke_t;

  typedef struct packed {
    logic [7:0] actOk;
    logic [7:0] preOk;
    logic [7:0] rwOk;
    logic [7:0] bstOk;
    logic rdOk;
    logic wrOk;
    logic refOk;
    logic anyOk;
  } stc_allow_t;

  typedef struct packed {
    logic sharedBusFlag;
    logic burstStopRestrict;
    logic bankCount;
    logic addressMappingMode;
    logic [2:0] driverCalibrationCode;
  } stc_cfg_out_t;

  typedef struct packed {
    logic [8:0] rsvd0;
    logic addressMappingMode;
    logic rsvd1;
    logic bankCount;
    logic rsvd2;
    logic burstStopRestrict;
    logic rsvd3;
    logic sharedBusFlag;
    logic rsvd4;
    logic [2:0] driverCalibrationCode;
    logic [11:0] rsvd5;
  } stc_cfg_t;

  typedef struct packed {
    logic [3:0] modeLoadDelay;
    logic shortenWrRdBit;
    logic [2:0] internalWrToRdDelay;
    logic [3:0] bankToBankActDelay;
    logic [3:0] prechargeDelay;
    logic [3:0] rowCycleDelay;
    logic [3:0] writeRecoveryDelay;
    logic [3:0] rowToColDelay;
    logic [3:0] actToPreDelay;
  } stc_tpr0_t;

  typedef struct packed {
    logic [3:0] rsvd0;
    logic [3:0] powerdownExitDelay;
    logic [7:0] selfrefExitReadDelay;
    logic [7:0] selfrefExitNonreadDelay;
    logic [2:0] rsvd1;
    logic [4:0] refreshCycleDelay;
  } stc_tpr1_t;

  typedef struct packed {
    logic [11:0] rsvd0;
    logic [3:0] fourActWindow;
    logic rsvd1;
    logic [2:0] readToPreDelay;
    logic [3:0] prechargeAllDelay;
    logic [3:0] slowExitReadDelay;
    logic [3:0] fastExitReadDelay;
  } stc_tpr2_t;

endpackage : stc_pkg

// file: hdl/stc_timing_config.sv
`timescale 1ns/1ps
// Behaviour
// R1: software uses calibration code 7 then 0; field resets to 7
// R2: shared bus flag, reset 0 alone, 1 shares external bus
// R3: restrict bit 1 forbids burst stop to another bank after activate
// R4: bank count 0 gives four banks, 1 gives eight (DDR2 only); logic gives eight on every memory type
// R5: address mapping 0 sequential (reset), 1 interleaved
// R6: timing registers ignore writes while write protect is set
// R7: activate to precharge same bank spaced by programmed count
// R8: activate to read or write same row spaced by programmed count
// R9: write to precharge honours programmed write recovery count
// R10: activate to refresh spaced by row cycle count
// R11: after precharge wait programmed count before any command
// R12: activates to different banks spaced by bank-to-bank count
// R13: write-to-read count direct on DDR2, code 0/1 means 1/2 on LPDDR1
// R14: shorten bit cuts write-to-read by one; field must stay 0; logic applies the cut on LPDDR1 only
// R15: after mode load wait count before activate or refresh
// R16: after refresh wait count before activate or refresh
// R17: self-refresh exit waits count before any non-read command; burst stop permission does not wait
// R18: DDR self-refresh exit waits count before read; 0 on LPDDR1; logic loads the count on LPDDR1 as on DDR2
// R19: power-down exit waits count before first command; logic waits on DDR2 and LPDDR1 only
// R20: DDR2 fast active power-down exit waits count before read
// R21: DDR2 slow active power-down exit waits count before read
// R22: DDR2 precharge-all waits count before any command
// R23: each spacing is a reloaded down-counter gating dependent command
module stc_timing_config (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire stc_pkg::stc_mem_t memType,
  input wire stc_pkg::stc_cmd_t cmd,
  input wire stc_pkg::stc_cke_t cke,
  output stc_pkg::stc_allow_t allow,
  output stc_pkg::stc_cfg_out_t cfgOut
);
  import stc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] regSel(input logic [31:0] a);
    regSel = {a == WPMR_ADDR, a == TPR2_ADDR, a == TPR1_ADDR,
      a == TPR0_ADDR, a == CFG_ADDR};
  endfunction : regSel

  // a spacing of n cycles reloads the counter with n-1
  function automatic logic [CNT_W-1:0] loadVal(input logic [CNT_W-1:0] n);
    loadVal = (n == '0) ? '0 : n - 8'h01;
  endfunction : loadVal

  function automatic logic [CNT_W-1:0] tick(input logic [CNT_W-1:0] c,
    input logic ld, input logic [CNT_W-1:0] n);
    if (ld)
      tick = loadVal(n);
    else
      tick = (c == '0) ? '0 : c - 8'h01;
  endfunction : tick

  function automatic logic opIs(input stc_cmd_t c, input stc_op_t o);
    opIs = c.valid && (c.op == o);
  endfunction : opIs

  // ----------------------------------------------------------------
  // registers and apb slave
  // ----------------------------------------------------------------
  logic [31:0] cfg_q, tpr0_q, tpr1_q, tpr2_q, wpmr_q, prdata_q, rdMux;
  logic pready_q, pslverr_q, setup, wrEn, wpOn;
  logic [4:0] sel;
  stc_cfg_t c;
  stc_tpr0_t t0;
  stc_tpr1_t t1;
  stc_tpr2_t t2;

  assign c = stc_cfg_t'(cfg_q);
  assign t0 = stc_tpr0_t'(tpr0_q);
  assign t1 = stc_tpr1_t'(tpr1_q);
  assign t2 = stc_tpr2_t'(tpr2_q);
  assign sel = regSel(paddr);
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pready_q && pwrite;
  assign wpOn = wpmr_q[0];
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  always_comb
  begin
    rdMux = '0;
    unique case (1'b1)
      sel[0]: rdMux = cfg_q;
      sel[1]: rdMux = tpr0_q;
      sel[2]: rdMux = tpr1_q;
      sel[3]: rdMux = tpr2_q;
      sel[4]: rdMux = wpmr_q;
      default: rdMux = '0;
    endcase
  end

  // zero wait states: pready rises in the access cycle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && (sel == '0);
      if (setup && !pwrite)
        prdata_q <= rdMux;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q <= CFG_RST;
      tpr0_q <= TPR0_RST;
      tpr1_q <= TPR1_RST;
      tpr2_q <= TPR2_RST;
      wpmr_q <= WPMR_RST;
    end
    else if (wrEn)
    begin
      if (sel[4])
        wpmr_q <= pwdata & WPMR_WMASK;
      if (!wpOn) // R6
      begin
        if (sel[0])
          cfg_q <= pwdata & CFG_WMASK; // R1 R2 R3 R4 R5
        if (sel[1])
          tpr0_q <= pwdata & TPR0_WMASK;
        if (sel[2])
          tpr1_q <= pwdata & TPR1_WMASK;
        if (sel[3])
          tpr2_q <= pwdata & TPR2_WMASK;
      end
    end
  end

  assign cfgOut.sharedBusFlag = c.sharedBusFlag; // R2
  assign cfgOut.burstStopRestrict = c.burstStopRestrict;
  assign cfgOut.bankCount = c.bankCount;
  assign cfgOut.addressMappingMode = c.addressMappingMode; // R5
  assign cfgOut.driverCalibrationCode = c.driverCalibrationCode;

  // ----------------------------------------------------------------
  // global spacing counters
  // ----------------------------------------------------------------
  logic [2:0] bankEff;
  logic isDdr, isDdr2;
  logic [CNT_W-1:0] wtrEff;
  logic [G_NUM-1:0] gLoad;
  logic [CNT_W-1:0] gVal [G_NUM], gCnt_d [G_NUM], gCnt_q [G_NUM];

  assign bankEff = {cmd.bank[2] & c.bankCount, cmd.bank[1:0]}; // R4
  assign isDdr = (memType == MEM_DDR2) || (memType == MEM_LPDDR1);
  assign isDdr2 = memType == MEM_DDR2;

  always_comb
  begin
    wtrEff = '0;
    if (isDdr2)
      wtrEff = CNT_W'(t0.internalWrToRdDelay); // R13
    else if (memType == MEM_LPDDR1)
    begin
      wtrEff = t0.internalWrToRdDelay[0] ? 8'h02 : 8'h01; // R13
      if (t0.shortenWrRdBit)
        wtrEff = wtrEff - 8'h01; // R14
    end
  end

  always_comb
  begin
    gLoad = '0;
    gVal = '{default: '0};
    gLoad[G_RC] = opIs(cmd, OP_ACT); // R10
    gVal[G_RC] = CNT_W'(t0.rowCycleDelay);
    gLoad[G_RRD] = opIs(cmd, OP_ACT); // R12
    gVal[G_RRD] = CNT_W'(t0.bankToBankActDelay);
    gLoad[G_RP] = opIs(cmd, OP_PRE) || (opIs(cmd, OP_PREA) && !isDdr2); // R11
    gVal[G_RP] = CNT_W'(t0.prechargeDelay);
    gLoad[G_RPA] = opIs(cmd, OP_PREA) && isDdr2; // R22
    gVal[G_RPA] = CNT_W'(t2.prechargeAllDelay);
    gLoad[G_MRD] = opIs(cmd, OP_LMR); // R15
    gVal[G_MRD] = CNT_W'(t0.modeLoadDelay);
    gLoad[G_RFC] = opIs(cmd, OP_REF); // R16
    gVal[G_RFC] = CNT_W'(t1.refreshCycleDelay);
    gLoad[G_WTR] = opIs(cmd, OP_WR); // R13 R14
    gVal[G_WTR] = wtrEff;
    gLoad[G_XSNR] = cke.rise && (cke.cause == CKE_SELFREF); // R17
    gVal[G_XSNR] = t1.selfrefExitNonreadDelay;
    gLoad[G_XSRD] = gLoad[G_XSNR] && isDdr; // R18
    gVal[G_XSRD] = t1.selfrefExitReadDelay;
    gLoad[G_XP] = cke.rise && (cke.cause != CKE_SELFREF) && isDdr; // R19
    gVal[G_XP] = CNT_W'(t1.powerdownExitDelay);
    gLoad[G_XARD] = cke.rise && (cke.cause == CKE_PD_FAST) && isDdr2; // R20
    gVal[G_XARD] = CNT_W'(t2.fastExitReadDelay);
    gLoad[G_XARDS] = cke.rise && (cke.cause == CKE_PD_SLOW) && isDdr2; // R21
    gVal[G_XARDS] = CNT_W'(t2.slowExitReadDelay);
  end

  always_comb
    for (int i = 0; i < G_NUM; i++)
      gCnt_d[i] = tick(gCnt_q[i], gLoad[i], gVal[i]); // R23

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      gCnt_q <= '{default: '0};
    else
      gCnt_q <= gCnt_d;
  end

  // ----------------------------------------------------------------
  // per-bank counters and command permissions
  // ----------------------------------------------------------------
  logic [2:0] lastAct_q, lastAct_d;
  logic actSeen_q, actSeen_d, base, nonRd;
  stc_allow_t allow_d, allow_q;
  logic [CNT_W-1:0] rasCnt_q [NBANK], rcdCnt_q [NBANK], wrCnt_q [NBANK];

  // the activate taken at this edge already counts as the last one
  assign lastAct_d = opIs(cmd, OP_ACT) ? bankEff : lastAct_q;
  assign actSeen_d = actSeen_q || opIs(cmd, OP_ACT);
  assign allow = allow_q;
  assign base = (gCnt_d[G_RP] == '0) && (gCnt_d[G_RPA] == '0) &&
    (gCnt_d[G_XP] == '0); // R11 R22 R19
  assign nonRd = gCnt_d[G_XSNR] == '0; // R17

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lastAct_q <= '0;
      actSeen_q <= 1'b0;
    end
    else
    begin
      lastAct_q <= lastAct_d;
      actSeen_q <= actSeen_d;
    end
  end

  for (genvar b = 0; b < NBANK; b++)
  begin : g_bank
    logic hit, bankOk;
    logic [CNT_W-1:0] rasCnt_d, rcdCnt_d, wrCnt_d;
    assign hit = bankEff == 3'(b);
    assign bankOk = (b < 4) || c.bankCount; // R4
    assign rasCnt_d = tick(rasCnt_q[b], opIs(cmd, OP_ACT) && hit,
      CNT_W'(t0.actToPreDelay)); // R7
    assign rcdCnt_d = tick(rcdCnt_q[b], opIs(cmd, OP_ACT) && hit,
      CNT_W'(t0.rowToColDelay)); // R8
    assign wrCnt_d = tick(wrCnt_q[b], opIs(cmd, OP_WR) && hit,
      CNT_W'(t0.writeRecoveryDelay)); // R9
    always_ff @(posedge ref_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        rasCnt_q[b] <= '0;
        rcdCnt_q[b] <= '0;
        wrCnt_q[b] <= '0;
      end
      else
      begin
        rasCnt_q[b] <= rasCnt_d;
        rcdCnt_q[b] <= rcdCnt_d;
        wrCnt_q[b] <= wrCnt_d;
      end
    end
    assign allow_d.actOk[b] = bankOk && base && nonRd &&
      (gCnt_d[G_MRD] == '0) && (gCnt_d[G_RFC] == '0) &&
      ((gCnt_d[G_RRD] == '0) || (lastAct_d == 3'(b))); // R12 R15 R16
    assign allow_d.preOk[b] = bankOk && base && nonRd &&
      (rasCnt_d == '0) && (wrCnt_d == '0); // R7 R9
    assign allow_d.rwOk[b] = bankOk && base && (rcdCnt_d == '0); // R8
    assign allow_d.bstOk[b] = bankOk && base && (!c.burstStopRestrict ||
      !actSeen_d || (lastAct_d == 3'(b))); // R3
  end

  assign allow_d.rdOk = base && (gCnt_d[G_WTR] == '0) &&
    (gCnt_d[G_XSRD] == '0) && (gCnt_d[G_XARD] == '0) &&
    (gCnt_d[G_XARDS] == '0); // R18 R20 R21 R13
  assign allow_d.wrOk = base && nonRd;
  assign allow_d.refOk = base && nonRd && (gCnt_d[G_RC] == '0) &&
    (gCnt_d[G_MRD] == '0) && (gCnt_d[G_RFC] == '0); // R10 R15 R16
  assign allow_d.anyOk = base && nonRd;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      allow_q <= '0;
    else
      allow_q <= allow_d;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence actB0;
    opIs(cmd, OP_ACT) && (bankEff == 3'h0);
  endsequence

  sequence quietB0;
    !(opIs(cmd, OP_ACT) && (bankEff == 3'h0)) [*3];
  endsequence

  AST_WP_HOLD: assert property (wrEn && wpOn && (sel[3:0] != '0) |=> // R6
    $stable(tpr0_q) && $stable(tpr1_q) && $stable(tpr2_q) && $stable(cfg_q))
    else $error("protected register changed");
  AST_RAS: assert property (actB0 and (t0.actToPreDelay == 4'h3) |=> // R7
    !allow.preOk[0] [*2])
    else $error("precharge allowed too early after activate");
  AST_RAS_CNT: assert property ((actB0 and (t0.actToPreDelay == 4'h3)) // R23
    ##1 quietB0 |-> rasCnt_q[0] == '0)
    else $error("activate counter did not expire");
  AST_RCD: assert property (actB0 and (t0.rowToColDelay >= 4'h2) |=> // R8
    !allow.rwOk[0])
    else $error("column access allowed too early");
  AST_WR: assert property (opIs(cmd, OP_WR) && (bankEff == 3'h0) && // R9
    (t0.writeRecoveryDelay >= 4'h2) |=> !allow.preOk[0])
    else $error("write recovery not honoured");
  AST_RC: assert property (opIs(cmd, OP_ACT) && // R10
    (t0.rowCycleDelay >= 4'h2) |=> !allow.refOk)
    else $error("refresh allowed too early after activate");
  AST_RP: assert property (opIs(cmd, OP_PRE) && // R11
    (t0.prechargeDelay >= 4'h2) |=> !allow.anyOk ##0 !allow.rdOk)
    else $error("command allowed during precharge");
  AST_RRD: assert property (actB0 and (t0.bankToBankActDelay >= 4'h2) // R12
    |=> !allow.actOk[1])
    else $error("bank to bank activate too close");
  AST_MRD: assert property (opIs(cmd, OP_LMR) && // R15
    (t0.modeLoadDelay >= 4'h2) |=> !allow.actOk[0] && !allow.refOk)
    else $error("activate allowed after mode load");
  AST_RFC: assert property (opIs(cmd, OP_REF) && // R16
    (t1.refreshCycleDelay >= 5'h02) |=> !allow.refOk && !allow.actOk[0])
    else $error("refresh spacing violated");
  AST_XP: assert property (cke.rise && (cke.cause == CKE_PD_PRE) && // R19
    isDdr && (t1.powerdownExitDelay >= 4'h2) |=> !allow.anyOk)
    else $error("command allowed after power-down exit");
  AST_NB: assert property (!c.bankCount |=> allow.actOk[7:4] == '0) // R4
    else $error("upper banks enabled in four bank mode");

endmodule : stc_timing_config

// file: verif/stc_seq_model.sv
`timescale 1ns/1ps
module stc_seq_model (
  input wire logic ref_clk,
  output stc_pkg::stc_cmd_t cmd,
  output stc_pkg::stc_cke_t cke
);
  import stc_pkg::*;

  initial
  begin
    cmd = '0;
    cke = '0;
  end

  // ------------------------------------------------------------
  // one-cycle command pulse; idle lines scrambled after release
  // ------------------------------------------------------------
  task automatic issue(input stc_op_t op, input logic [2:0] bank);
    @(posedge ref_clk);
    cmd <= '{valid: 1'b1, op: op, bank: bank};
    @(posedge ref_clk);
    cmd <= '{valid: 1'b0, op: stc_op_t'(~op), bank: ~bank};
  endtask : issue

  task automatic wake(input stc_cke_cause_t cause);
    @(posedge ref_clk);
    cke <= '{rise: 1'b1, cause: cause};
    @(posedge ref_clk);
    cke <= '{rise: 1'b0, cause: stc_cke_cause_t'(~cause)};
  endtask : wake
endmodule : stc_seq_model

// file: verif/stc_timing_config_tb.sv
`timescale 1ns/1ps
module stc_timing_config_tb;
  import stc_pkg::*;

  typedef struct {string name; int bitSel; int exp;} stc_gap_t;
  typedef struct {logic [31:0] d; logic err; logic rd;} stc_bus_t;

  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, cfgV, v;
  logic [31:0] tpr [3];
  logic [35:0] av;
  logic [3:0] f;
  stc_mem_t memType;
  stc_cmd_t cmd;
  stc_cke_t cke;
  stc_allow_t allow;
  stc_cfg_out_t cfgOut;
  int miscompares, num_checks, nDone, k;
  stc_gap_t gq [$];
  stc_bus_t bq [$];
  stc_gap_t g;
  stc_bus_t b;

  assign av = allow;

  stc_timing_config uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memType(memType), .cmd(cmd), .cke(cke), .allow(allow),
    .cfgOut(cfgOut));

  stc_seq_model seq (.ref_clk(ref_clk), .cmd(cmd), .cke(cke));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [35:0] seen,
    input logic [35:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  function automatic int rnd(input int lo, input int hi);
    return lo + int'($urandom % (hi - lo + 1));
  endfunction : rnd

  task automatic apb(input logic wr, input logic [31:0] a,
    input logic [31:0] d, input logic err, input logic [31:0] e);
    int i;
    bq.push_back('{e, err, !wr});
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1 && ++i < 50);
    if (i >= 50)
      miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0);
  endtask : wreg

  task automatic rreg(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0, e);
  endtask : rreg

  // program one timing field, start the spacing, note the expected gap
  task automatic gap(input string name, input int r, input int lsb,
    input int w, input int n, input stc_op_t op, input int ck,
    input int bitSel, input int e);
    int tgt;
    logic [31:0] m;
    m = ((32'h1 << w) - 32'h1) << lsb;
    tpr[r] = (tpr[r] & ~m) | ((n << lsb) & m);
    wreg(r == 0 ? TPR0_ADDR : r == 1 ? TPR1_ADDR : TPR2_ADDR, tpr[r]);
    gq.push_back('{name, bitSel, e >= 0 ? e : (n > 1 ? n : 1)});
    tgt = nDone + 1;
    if (ck < 0)
      seq.issue(op, 3'h0);
    else
      seq.wake(stc_cke_cause_t'(ck));
    repeat (400) if (nDone < tgt) @(posedge ref_clk);
    if (nDone < tgt)
      miscompares++;
    repeat (64) @(posedge ref_clk);
  endtask : gap

  // ------------------------------------------------------------
  // monitors
  // ------------------------------------------------------------
  always @(posedge ref_clk)
    if (psel && penable && pready && bq.size() > 0)
    begin
      b = bq.pop_front();
      chk("pslverr", {35'h0, pslverr}, {35'h0, b.err});
      if (b.rd)
        chk("prdata", {4'h0, prdata}, {4'h0, b.d});
    end

  always
  begin
    @(negedge ref_clk);
    if ((cmd.valid || cke.rise) && gq.size() > 0)
    begin
      g = gq.pop_front();
      k = 1;
      @(negedge ref_clk);
      while (av[g.bitSel] !== 1'b1 && k < 300)
      begin
        k++;
        @(negedge ref_clk);
      end
      chk(g.name, 36'(k), 36'(g.exp));
      nDone++;
    end
  end

  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #(25 * 40000);
    miscompares++;
    end_sim();
  end

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    memType = MEM_DDR2;
    miscompares = 0;
    num_checks = 0;
    nDone = 0;
    tpr[0] = 32'h20227225;
    tpr[1] = 32'h03c80808;
    tpr[2] = 32'h00042062;
    void'($urandom(81));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk("cfgOut", {29'h0, cfgOut}, 36'h7);
    rreg(CFG_ADDR, 32'h00007000);
    rreg(TPR0_ADDR, tpr[0]);
    rreg(TPR1_ADDR, tpr[1]);
    rreg(TPR2_ADDR, tpr[2]);
    apb(1'b0, 32'h0fffe800, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 32'h0fffe800, 32'hffffffff, 1'b1, 32'h0);
    // calibration code 7 before 0, each flag both ways
    for (int i = 0; i < 2; i++)
    begin
      f = i ? ~f : 4'($urandom);
      v = {9'h0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0], 1'b0,
        i ? 3'h0 : 3'h7, 12'h0};
      wreg(CFG_ADDR, v);
      rreg(CFG_ADDR, v);
      chk("cfgOut", {29'h0, cfgOut}, {29'h0, v[16], v[18], v[20], v[22],
        v[14:12]});
    end
    for (int i = 0; i < 2; i++)
    begin
      wreg(CFG_ADDR, i ? 32'h00100000 : 32'h0);
      repeat (3) @(negedge ref_clk);
      chk("actOk7", {35'h0, allow.actOk[7]}, 36'(i));
    end
    memType <= MEM_SDR;
    for (int i = 0; i < 2; i++)
    begin
      wreg(CFG_ADDR, i ? 32'h00040000 : 32'h0);
      seq.issue(OP_ACT, 3'h2);
      repeat (3) @(negedge ref_clk);
      chk("bstOk1", {35'h0, allow.bstOk[1]}, 36'(1 - i));
      chk("bstOk2", {35'h0, allow.bstOk[2]}, 36'h1);
      repeat (20) @(posedge ref_clk);
    end
    cfgV = 32'h00040000;
    wreg(WPMR_ADDR, 32'h1);
    for (int j = 0; j < 4; j++)
    begin
      v = j == 0 ? cfgV : tpr[j - 1];
      wreg(j == 0 ? CFG_ADDR : j == 1 ? TPR0_ADDR : j == 2 ? TPR1_ADDR
        : TPR2_ADDR, ~v);
      rreg(j == 0 ? CFG_ADDR : j == 1 ? TPR0_ADDR : j == 2 ? TPR1_ADDR
        : TPR2_ADDR, v);
    end
    wreg(WPMR_ADDR, 32'h0);
    rreg(WPMR_ADDR, 32'h0);
    wreg(CFG_ADDR, 32'h0);
    memType <= MEM_DDR2;
    gap("actToPre", 0, 0, 4, rnd(2, 15), OP_ACT, -1, 20, -1);
    gap("actToPre3", 0, 0, 4, 3, OP_ACT, -1, 20, -1);
    gap("rowToCol", 0, 4, 4, rnd(2, 15), OP_ACT, -1, 12, -1);
    gap("wrRecov", 0, 8, 4, rnd(1, 15), OP_WR, -1, 20, -1);
    gap("rowCycle", 0, 12, 4, rnd(2, 15), OP_ACT, -1, 1, -1);
    gap("precharge", 0, 16, 4, rnd(2, 15), OP_PRE, -1, 0, -1);
    gap("bankToBank", 0, 20, 4, rnd(2, 15), OP_ACT, -1, 29, -1);
    gap("wrToRd", 0, 24, 3, rnd(1, 7), OP_WR, -1, 3, -1);
    gap("modeLoad", 0, 28, 4, rnd(2, 15), OP_LMR, -1, 1, -1);
    gap("refresh", 1, 0, 5, rnd(2, 31), OP_REF, -1, 28, -1);
    gap("exitNonrd", 1, 8, 8, rnd(2, 60), OP_NOP, 0, 2, -1);
    gap("exitRd", 1, 16, 8, rnd(2, 60), OP_NOP, 0, 3, -1);
    gap("fastExit", 2, 0, 4, rnd(4, 15), OP_NOP, 2, 3, -1);
    gap("slowExit", 2, 4, 4, rnd(4, 15), OP_NOP, 3, 3, -1);
    gap("pdExit", 1, 24, 4, rnd(2, 15), OP_NOP, 1, 0, -1);
    gap("prechAll", 2, 8, 4, rnd(0, 15), OP_PREA, -1, 0, -1);
    memType <= MEM_LPDDR1;
    gap("wrToRdLp", 0, 24, 3, 1, OP_WR, -1, 3, 2);
    gap("wrToRdCut", 0, 24, 4, 8, OP_WR, -1, 3, 1);
    rreg(TPR0_ADDR, tpr[0]);
    rreg(TPR1_ADDR, tpr[1]);
    rreg(TPR2_ADDR, tpr[2]);
    end_sim();
  end
endmodule : stc_timing_config_tb
